// File: shared/cmc_params.svh
// constants for the console master control block
// assumes a 125 MHz system clock and a millisecond tick prescaler
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
// clock and tick
`define CMC_SYS_CLK_HZ 125000000
`define CMC_TICK_US 1000
`define CMC_CYC_PER_TICK (`CMC_TICK_US * (`CMC_SYS_CLK_HZ / 1000000))
// durations in ms or s
`define CMC_HOLD1_MS 12'd1000
`define CMC_HOLD3_MS 12'd3000
`define CMC_SLEEP_HOLD_MS 12'd3000
`define CMC_RIPPLE_MS 12'd125
`define CMC_SEQ_STEP_MS 12'd200
`define CMC_PULSE_MS 10'd1000
`define CMC_MS_PER_S 10'd1000
`define CMC_WARN_S 13'd60
`define CMC_IDLE_MIN_S 13'd15
`define CMC_IDLE_MAX_S 13'd4500
// register offsets
`define CMC_REG_CTRL 4'h0
`define CMC_REG_IDLE 4'h4
`define CMC_REG_STAT 4'h8
// field positions
`define CMC_CTRL_AUTO 0
`define CMC_CTRL_MODE 1
// reset values
`define CMC_IDLE_RST 13'd900
`define CMC_MODE_RST 2'h0
`endif

// File: shared/cmc_pkg.sv
// types for the console master control block
// assumes cmc_params.svh is compiled alongside
package cmc_pkg;
    // peak hold modes in press order
    typedef enum logic [1:0] {
        PK_NONE = 2'h0,
        PK_1S = 2'h1,
        PK_3S = 2'h2,
        PK_PERM = 2'h3
    } cmc_pk_mode_t;
    // sleep sequencer, one-hot
    typedef enum logic [7:0] {
        S_AWAKE = 8'h01,
        S_DN_MON = 8'h02,
        S_DN_MST = 8'h04,
        S_DN_CHN = 8'h08,
        S_ASLEEP = 8'h10,
        S_UP_CHN = 8'h20,
        S_UP_MST = 8'h40,
        S_UP_MON = 8'h80
    } cmc_slp_t;
    // one-cycle button press pulses
    typedef struct packed {
        logic peak_cycle;
        logic peak_clear;
        logic chan_dim;
        logic mon_dim;
        logic follow;
        logic red_light;
        logic route;
        logic comms;
    } cmc_btn_t;
    // meter brightness, 1 = dim
    typedef struct packed {
        logic chan;
        logic bus;
        logic mon;
        logic mix;
    } cmc_dim_t;
    // power stages, 1 = on or closed
    typedef struct packed {
        logic mon_relay;
        logic master_rail;
        logic chan_rail;
    } cmc_rail_t;
endpackage

// File: rtl/cmc_master_ctrl.sv
// master section panel control: peak hold, dimming, modifier key,
// record lamp, sleep and power sequencing
// assumes all panel inputs are debounced and synchronous to clk_sys_i
`timescale 1ns/1ps
`include "cmc_params.svh"
module cmc_master_ctrl import cmc_pkg::*; #(
    parameter int CYC_PER_TICK = `CMC_CYC_PER_TICK
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_i, // sync reset, high
    input wire cmc_btn_t btn_i, // press pulses
    input wire logic modifier_i, // modifier key level
    input wire logic power_key_i, // power key level
    input wire logic xp_select_i, // routing in select mode
    input wire logic [5:0] route_path_i, // path of route press
    input wire logic [7:0] peak_hit_i, // peak capture per section
    input wire logic meter_act_i, // any meter activity
    input wire logic [3:0] addr_i, // register address
    input wire logic [31:0] wdata_i, // write data
    input wire logic we_i, // write strobe
    input wire logic re_i, // read strobe
    output logic [31:0] rdata_o, // read data
    output logic [7:0] peak_led_o, // peak indicator LEDs
    output logic [7:0] top_led_o, // top red LEDs
    output cmc_dim_t dim_o, // meter dim states
    output logic follow_o, // mix meter follows monitor source
    output logic xp_cancel_o, // cancel select pulse
    output logic xp_clear_o, // clear crosspoints pulse
    output logic [5:0] xp_path_o, // path to clear
    output logic red_led_o, // record lamp LED
    output logic red_relay_o, // record lamp relay
    output logic power_led_o, // power key LED
    output cmc_rail_t rail_o // power stages
);
    // ms countdown length of a timed mode
    function automatic logic [11:0] hold_ms(input cmc_pk_mode_t m);
        logic [11:0] r;
        r = 12'h000;
        if (m == PK_1S) r = `CMC_HOLD1_MS;
        if (m == PK_3S) r = `CMC_HOLD3_MS;
        return r;
    endfunction

    // tick prescaler state
    logic [31:0] pre_q, pre_d; // cycle count
    logic tick_q, tick_d; // 1 ms pulse
    logic [9:0] ms_q, ms_d; // ms within second
    logic sec_q, sec_d; // 1 s pulse

    // prescaler next values
    always_comb begin
        pre_d = pre_q + 32'h0000_0001;
        tick_d = 1'b0;
        if (pre_q >= 32'(CYC_PER_TICK - 1)) begin
            pre_d = 32'h0000_0000;
            tick_d = 1'b1;
        end
        ms_d = ms_q;
        sec_d = 1'b0;
        if (tick_q) begin
            ms_d = ms_q + 10'h001;
            if (ms_q == `CMC_MS_PER_S - 10'h001) begin
                ms_d = 10'h000;
                sec_d = 1'b1;
            end
        end
    end

    // prescaler registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre_q <= 32'h0000_0000;
            tick_q <= 1'b0;
            ms_q <= 10'h000;
            sec_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            tick_q <= tick_d;
            ms_q <= ms_d;
            sec_q <= sec_d;
        end
    end

    // panel state
    cmc_pk_mode_t mode_q, mode_d; // peak hold mode
    logic mode_chg; // mode changed this cycle
    cmc_dim_t dim_q, dim_d; // dim states
    logic follow_q, follow_d; // source follow
    logic red_q, red_d; // record lamp
    logic auto_q, auto_d; // idle sleep enable
    logic [12:0] idle_s_q, idle_s_d; // idle timeout in s
    logic mod_prev_q; // modifier last cycle
    logic cancel_q, cancel_d; // cancel pulse
    logic clear_q, clear_d; // clear pulse
    logic [5:0] path_q, path_d; // cleared path
    logic [31:0] rd_q, rd_d; // read data
    logic asleep; // any state but awake
    logic warn; // idle warning window
    logic relay_q, relay_d; // relay drive
    cmc_slp_t slp_q, slp_d; // sleep sequencer

    // panel next values
    always_comb begin
        mode_d = mode_q;
        dim_d = dim_q;
        follow_d = follow_q;
        red_d = red_q;
        auto_d = auto_q;
        idle_s_d = idle_s_q;
        cancel_d = 1'b0;
        clear_d = 1'b0;
        path_d = path_q;
        rd_d = 32'h0000_0000;
        // software restores the mode kept over power off
        if (we_i && addr_i == `CMC_REG_CTRL) begin
            auto_d = wdata_i[`CMC_CTRL_AUTO];
            mode_d = cmc_pk_mode_t'(wdata_i[`CMC_CTRL_MODE +: 2]);
        end
        if (we_i && addr_i == `CMC_REG_IDLE) idle_s_d = wdata_i[12:0];
        // press advances from the held mode, wraps to none
        if (btn_i.peak_cycle) mode_d = cmc_pk_mode_t'(mode_q + 2'h1);
        // modifier picks the alternate meter group
        if (btn_i.chan_dim) begin
            if (modifier_i) dim_d.bus = ~dim_q.bus;
            else dim_d.chan = ~dim_q.chan;
        end
        if (btn_i.mon_dim) begin
            if (modifier_i) dim_d.mix = ~dim_q.mix;
            else dim_d.mon = ~dim_q.mon;
        end
        if (btn_i.follow) follow_d = ~follow_q;
        if (btn_i.red_light) red_d = ~red_q;
        // modifier press escapes select mode
        if (modifier_i && !mod_prev_q && xp_select_i) cancel_d = 1'b1;
        // held modifier plus route clears that path
        if (modifier_i && btn_i.route) begin
            clear_d = 1'b1;
            path_d = route_path_i;
        end
        // register reads
        if (re_i) begin
            unique case (addr_i)
                `CMC_REG_CTRL: rd_d = {29'h0, mode_q, auto_q};
                `CMC_REG_IDLE: rd_d = {19'h0, idle_s_q};
                `CMC_REG_STAT: rd_d = {22'h0, warn, asleep, relay_q, red_q,
                                       follow_q, dim_q, 1'b0};
                default: rd_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
        // relay flips whenever the console sleeps
        relay_d = red_d ^ (slp_d != S_AWAKE);
    end
    assign mode_chg = (mode_d != mode_q);

    // panel registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q <= PK_NONE;
            dim_q <= '0;
            follow_q <= 1'b0;
            red_q <= 1'b0;
            auto_q <= 1'b0;
            idle_s_q <= `CMC_IDLE_RST;
            mod_prev_q <= 1'b0;
            cancel_q <= 1'b0;
            clear_q <= 1'b0;
            path_q <= 6'h00;
            rd_q <= 32'h0000_0000;
            relay_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            dim_q <= dim_d;
            follow_q <= follow_d;
            red_q <= red_d;
            auto_q <= auto_d;
            idle_s_q <= idle_s_d;
            mod_prev_q <= modifier_i;
            cancel_q <= cancel_d;
            clear_q <= clear_d;
            path_q <= path_d;
            rd_q <= rd_d;
            relay_q <= relay_d;
        end
    end

    // peak hold state
    logic [11:0] hold_q [8], hold_d [8]; // per section countdown
    logic [7:0] pk_q, pk_d; // peak LEDs
    logic [11:0] ind_q, ind_d; // indication countdown
    logic [7:0] rip_q, rip_d; // ripple position
    logic [7:0] top_q, top_d; // top LEDs

    // peak next values
    always_comb begin
        pk_d = pk_q;
        for (int i = 0; i < 8; i++) begin
            hold_d[i] = hold_q[i];
            if (mode_chg) begin
                hold_d[i] = 12'h000;
                pk_d[i] = 1'b0;
            end else begin
                unique case (mode_q)
                    PK_NONE: pk_d[i] = peak_hit_i[i];
                    PK_1S, PK_3S: begin
                        // restart on capture, else count down
                        if (peak_hit_i[i]) begin
                            pk_d[i] = 1'b1;
                            hold_d[i] = hold_ms(mode_q);
                        end else if (tick_q && hold_q[i] != 12'h000) begin
                            hold_d[i] = hold_q[i] - 12'h001;
                            if (hold_q[i] == 12'h001) pk_d[i] = 1'b0;
                        end
                    end
                    PK_PERM: begin
                        // capture wins over a clear in the same cycle
                        if (btn_i.peak_clear) pk_d[i] = 1'b0;
                        if (peak_hit_i[i]) pk_d[i] = 1'b1;
                    end
                endcase
            end
        end
        // mode indication on the top LEDs
        ind_d = ind_q;
        rip_d = rip_q;
        if (mode_chg) begin
            ind_d = (mode_d == PK_PERM) ? `CMC_RIPPLE_MS : hold_ms(mode_d);
            rip_d = (mode_d == PK_PERM) ? 8'h01 : 8'h00;
        end else if (tick_q && ind_q != 12'h000) begin
            ind_d = ind_q - 12'h001;
            // permanent mode walks across the eight sections
            if (ind_q == 12'h001 && rip_q != 8'h00) begin
                rip_d = {rip_q[6:0], 1'b0};
                if (rip_q[7] == 1'b0) ind_d = `CMC_RIPPLE_MS;
            end
        end
        if (rip_d != 8'h00) top_d = rip_d;
        else top_d = (ind_d != 12'h000) ? 8'hff : 8'h00;
    end

    // peak registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) hold_q[i] <= 12'h000;
            pk_q <= 8'h00;
            ind_q <= 12'h000;
            rip_q <= 8'h00;
            top_q <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) hold_q[i] <= hold_d[i];
            pk_q <= pk_d;
            ind_q <= ind_d;
            rip_q <= rip_d;
            top_q <= top_d;
        end
    end

    // power management state
    logic [11:0] key_q, key_d; // power key hold in ms
    logic [11:0] seq_q, seq_d; // sequence step in ms
    logic [12:0] idle_q, idle_d; // idle seconds
    logic [12:0] limit; // clamped timeout
    logic pkey_prev_q; // power key last cycle
    logic activity; // any use seen
    logic step_done; // sequence step elapsed
    logic [9:0] ph_q, ph_d; // pulse phase in ms
    logic [8:0] pwm_q, pwm_d; // pwm ramp
    logic [8:0] tri_lvl; // pulse brightness
    logic led_q, led_d; // power LED
    cmc_rail_t rail_q, rail_d; // stage outputs

    // timeout clamped into its legal span
    always_comb begin
        limit = idle_s_q;
        if (idle_s_q < `CMC_IDLE_MIN_S) limit = `CMC_IDLE_MIN_S;
        if (idle_s_q > `CMC_IDLE_MAX_S) limit = `CMC_IDLE_MAX_S;
    end
    // meters and the listed switch groups count as use
    assign activity = meter_act_i | (|peak_hit_i) | btn_i.route | btn_i.comms
        | btn_i.peak_cycle | btn_i.peak_clear | btn_i.chan_dim | btn_i.mon_dim
        | btn_i.follow;
    assign asleep = (slp_q != S_AWAKE);
    assign warn = auto_q && !asleep && (idle_q + `CMC_WARN_S >= limit);
    assign step_done = tick_q && (seq_q >= `CMC_SEQ_STEP_MS - 12'h001);
    assign tri_lvl = (ph_q < 10'd500) ? ph_q[8:0] : 9'(10'd999 - ph_q);

    // sequencer and timer next values
    always_comb begin
        slp_d = slp_q;
        seq_d = (tick_q) ? seq_q + 12'h001 : seq_q;
        key_d = 12'h000;
        if (power_key_i && slp_q == S_AWAKE)
            key_d = (tick_q) ? key_q + 12'h001 : key_q;
        idle_d = idle_q;
        if (activity || !auto_q || asleep) idle_d = 13'h0000;
        else if (sec_q) idle_d = idle_q + 13'h0001;
        unique case (slp_q)
            S_AWAKE: begin
                // held key or idle timeout starts shutdown
                if (key_q >= `CMC_SLEEP_HOLD_MS || (auto_q && idle_q >= limit))
                    slp_d = S_DN_MON;
            end
            S_DN_MON: if (step_done) slp_d = S_DN_MST;
            S_DN_MST: if (step_done) slp_d = S_DN_CHN;
            S_DN_CHN: if (step_done) slp_d = S_ASLEEP;
            // fresh press wakes; panel state was never cleared
            S_ASLEEP: if (power_key_i && !pkey_prev_q) slp_d = S_UP_CHN;
            S_UP_CHN: if (step_done) slp_d = S_UP_MST;
            S_UP_MST: if (step_done) slp_d = S_UP_MON;
            S_UP_MON: if (step_done) slp_d = S_AWAKE;
        endcase
        if (slp_d != slp_q) seq_d = 12'h000;
        // stages off from monitors inward, on from channels outward
        rail_d.mon_relay = (slp_d == S_AWAKE);
        rail_d.master_rail = (slp_d == S_AWAKE) || (slp_d == S_DN_MON)
            || (slp_d == S_UP_MST) || (slp_d == S_UP_MON);
        rail_d.chan_rail = (slp_d != S_DN_CHN) && (slp_d != S_ASLEEP);
        // pulse phase and pwm ramp
        ph_d = ph_q;
        if (tick_q) ph_d = (ph_q == `CMC_PULSE_MS - 10'h001) ? 10'h000 : ph_q + 10'h001;
        pwm_d = pwm_q + 9'h001;
        // LED: pulse asleep, flash in warning, lit when awake
        if (slp_q == S_ASLEEP) led_d = (pwm_q < tri_lvl);
        else if (warn) led_d = ph_q[6];
        else led_d = (slp_q == S_AWAKE);
    end

    // sequencer and timer registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            slp_q <= S_AWAKE;
            seq_q <= 12'h000;
            key_q <= 12'h000;
            idle_q <= 13'h0000;
            pkey_prev_q <= 1'b0;
            ph_q <= 10'h000;
            pwm_q <= 9'h000;
            led_q <= 1'b0;
            rail_q <= '0;
        end else begin
            slp_q <= slp_d;
            seq_q <= seq_d;
            key_q <= key_d;
            idle_q <= idle_d;
            pkey_prev_q <= power_key_i;
            ph_q <= ph_d;
            pwm_q <= pwm_d;
            led_q <= led_d;
            rail_q <= rail_d;
        end
    end

    // outputs straight from flops
    assign rdata_o = rd_q;
    assign peak_led_o = pk_q;
    assign top_led_o = top_q;
    assign dim_o = dim_q;
    assign follow_o = follow_q;
    assign xp_cancel_o = cancel_q;
    assign xp_clear_o = clear_q;
    assign xp_path_o = path_q;
    assign red_led_o = red_q;
    assign red_relay_o = relay_q;
    assign power_led_o = led_q;
    assign rail_o = rail_q;
endmodule // cmc_master_ctrl

// File: verification/cmc_props.sv
// port checker for the master control block
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
module cmc_props import cmc_pkg::*; #(
    parameter int CYC_PER_TICK = 4 // cycles per tick
) (
    input wire logic clk_sys_i, // clock
    input wire logic rst_i, // reset
    input wire cmc_btn_t btn_i, // presses
    input wire logic modifier_i, // modifier key
    input wire logic xp_select_i, // select mode
    input wire logic [5:0] route_path_i, // route path
    input wire logic re_i, // read strobe
    input wire logic [31:0] rdata_o, // read data
    input wire cmc_dim_t dim_o, // dim states
    input wire logic follow_o, // follow
    input wire logic xp_cancel_o, // cancel pulse
    input wire logic xp_clear_o, // clear pulse
    input wire logic [5:0] xp_path_o, // cleared path
    input wire logic red_led_o, // lamp led
    input wire logic red_relay_o, // lamp relay
    input wire cmc_rail_t rail_o // power stages
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [1:0] up_q; // cycles since reset, saturating
    logic [1:0] up_d; // next value
    // count settles so reset values are not judged
    always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    always_ff @(posedge clk_sys_i) up_q <= rst_i ? 2'h0 : up_d;

    chk_rdata_idle: assert property (!re_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");
    chk_chan_dim: assert property (
        btn_i.chan_dim && !modifier_i |=> dim_o.chan != $past(dim_o.chan) && $stable(dim_o.bus))
        else $error("channel dim did not toggle");
    chk_bus_dim: assert property (
        btn_i.chan_dim && modifier_i |=> dim_o.bus != $past(dim_o.bus) && $stable(dim_o.chan))
        else $error("bus dim did not toggle");
    chk_mix_dim: assert property (
        btn_i.mon_dim && modifier_i |=> dim_o.mix != $past(dim_o.mix) && $stable(dim_o.mon))
        else $error("mix dim did not toggle");
    chk_follow_flip: assert property (btn_i.follow |=> follow_o != $past(follow_o))
        else $error("follow did not toggle");
    chk_cancel_cause: assert property (
        xp_cancel_o |-> $past(modifier_i) && $past(xp_select_i))
        else $error("cancel without modifier in select");
    chk_clear_path: assert property (
        btn_i.route && modifier_i |=> xp_clear_o && xp_path_o == $past(route_path_i))
        else $error("crosspoint clear missing");
    chk_clear_cause: assert property (
        xp_clear_o |-> $past(btn_i.route) && $past(modifier_i))
        else $error("clear without modifier route");
    chk_master_after: assert property ($fell(rail_o.master_rail) |-> !rail_o.mon_relay)
        else $error("master rail off before monitors");
    chk_chan_after: assert property ($fell(rail_o.chan_rail) |-> !rail_o.master_rail)
        else $error("channel rail off before master");
    chk_mon_last: assert property (
        $rose(rail_o.mon_relay) |-> rail_o.master_rail && rail_o.chan_rail)
        else $error("monitors on before rails");
    chk_relay_awake: assert property (
        up_q == 2'h3 && rail_o == 3'h7 && $past(rail_o) == 3'h7 |-> red_relay_o == red_led_o)
        else $error("relay differs from lamp while awake");
    chk_relay_sleep: assert property (
        up_q == 2'h3 && rail_o == 3'h0 && $past(rail_o) == 3'h0 |-> red_relay_o != red_led_o)
        else $error("relay not flipped while asleep");
    cover property (xp_clear_o);
    cover property (xp_cancel_o);
    cover property (rail_o == 3'h0);
    cover property (red_relay_o != red_led_o);
endmodule // cmc_props

// File: verification/cmc_panel_model.sv
// panel side model: power key, rail and power led watcher
// assumes rails and led are sampled on the system clock
`timescale 1ns/1ps
module cmc_panel_model import cmc_pkg::*; (
    input wire logic clk_sys_i, // clock
    input wire cmc_rail_t rail_i, // rails seen
    input wire logic led_i, // power key led
    output logic key_o // power key level
);
    cmc_rail_t last_q = '0; // previous rail state
    logic led_q = 1'b0; // previous led level
    cmc_rail_t ev_q[$]; // rail state after each change
    int at_q[$]; // cycle of each change
    int cyc = 0; // cycle count
    int led_flips = 0; // led edges seen
    initial key_o = 1'b0;
    // log every rail change with its cycle, count led edges
    always @(posedge clk_sys_i) begin
        cyc++;
        if (rail_i !== last_q) begin
            ev_q.push_back(rail_i);
            at_q.push_back(cyc);
        end
        if (led_i !== led_q) led_flips++;
        last_q = rail_i;
        led_q = led_i;
    end
    // key level, changed just after an edge by the caller
    task automatic set_key(input logic v);
        key_o <= v;
    endtask
endmodule // cmc_panel_model

// File: verification/tb.sv
// self-checking bench for the master control block
// assumes a 2-cycle tick so second-long holds run in thousands of cycles
`timescale 1ns/1ps
`include "cmc_params.svh"
module tb import cmc_pkg::*;;
    localparam int TK = 2; // cycles per ms tick
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    cmc_btn_t btn_i = '0;
    logic modifier_i = 1'b0;
    logic xp_select_i = 1'b0;
    logic [5:0] route_path_i = 6'h0;
    logic [7:0] peak_hit_i = 8'h0;
    logic meter_act_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic power_key_i, follow_o, xp_cancel_o, xp_clear_o, red_led_o, red_relay_o, power_led_o;
    logic [31:0] rdata_o;
    logic [7:0] peak_led_o, top_led_o;
    logic [5:0] xp_path_o;
    cmc_dim_t dim_o;
    cmc_rail_t rail_o;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 80236;
    int m, j; // model peak mode, dim index
    logic [3:0] dm = 4'h0; // model dims chan,bus,mon,mix
    logic fol = 1'b0; // model follow
    logic lamp = 1'b0; // model record lamp
    logic [31:0] r; // scratch
    cmc_rail_t exp_ev[6] = '{3'h3, 3'h1, 3'h0, 3'h1, 3'h3, 3'h7}; // rail steps
    int steps[6] = '{0, 1, 1, 0, 1, 2}; // sequence steps between changes
    always #4 clk_sys_i = ~clk_sys_i;
    cmc_master_ctrl #(.CYC_PER_TICK(TK)) dut (.*);
    cmc_panel_model panel (.clk_sys_i(clk_sys_i), .rail_i(rail_o), .led_i(power_led_o),
        .key_o(power_key_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic ms(input int n);
        cyc(n * TK);
    endtask
    task automatic press(input cmc_btn_t b);
        @(posedge clk_sys_i);
        btn_i <= b;
        @(posedge clk_sys_i);
        btn_i <= '0;
        #1;
    endtask
    task automatic hit(input logic [7:0] v);
        @(posedge clk_sys_i);
        peak_hit_i <= v;
        @(posedge clk_sys_i);
        peak_hit_i <= 8'h0;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_ev(input int n);
        for (int i = 0; i < 1000 * TK && panel.ev_q.size() < n; i++) cyc(1);
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(12);
        rst_i <= 1'b0;
        rd(4'h4, r);
        chk(r, 32'(`CMC_IDLE_RST));
        wr(4'h4, 32'h0000_0005);
        rd(4'h4, r);
        chk(r, 32'h0000_0005);
        rd(4'hc, r);
        chk(r, 32'h0);
        $display("test registers finished");
        m = $random(seed) & 3;
        wr(4'h0, 32'(m << 1));
        for (int i = 0; i < 5; i++) begin
            press(8'h80); // peak cycle button
            m = (m + 1) % 4;
            rd(4'h0, r);
            chk(r[2:1], m);
            chk(top_led_o, m == 3 ? 8'h01 : (m == 0 ? 8'h00 : 8'hff));
        end
        for (int k = 1; k < 3; k++) begin
            wr(4'h0, 32'(k << 1));
            hit(8'h08);
            chk(peak_led_o, 8'h08);
            press(8'h40); // clear has no effect here
            chk(peak_led_o, 8'h08);
            ms((k == 1 ? `CMC_HOLD1_MS : `CMC_HOLD3_MS) - 100);
            chk(peak_led_o, 8'h08);
            ms(200);
            chk(peak_led_o, 8'h00);
        end
        wr(4'h0, 32'h0000_0006);
        hit(8'h10);
        ms(100);
        chk(peak_led_o, 8'h10);
        press(8'h40);
        chk(peak_led_o, 8'h00);
        wr(4'h0, 32'h0000_0000);
        r = $random(seed);
        hit(r[7:0]);
        chk(peak_led_o, r[7:0]);
        $display("test peak hold finished");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            modifier_i <= r[0];
            press(r[1] ? 8'h10 : 8'h20); // monitor or channel dim
            j = 3 - 2 * r[1] - r[0];
            dm[j] = ~dm[j];
            chk(dim_o, dm);
        end
        modifier_i <= 1'b0;
        press(8'h08);
        fol = 1'b1;
        chk(follow_o, fol);
        xp_select_i <= 1'b1;
        cyc(1);
        modifier_i <= 1'b1;
        for (int i = 0; i < 4 && xp_cancel_o !== 1'b1; i++) begin
            cyc(1);
            #1;
        end
        chk(xp_cancel_o, 1'b1);
        xp_select_i <= 1'b0;
        r = $random(seed);
        route_path_i <= r[13:8];
        press(8'h02); // route with modifier held
        chk({xp_clear_o, xp_path_o}, {1'b1, r[13:8]});
        modifier_i <= 1'b0;
        press(8'h02);
        chk(xp_clear_o, 1'b0);
        press(8'h04);
        lamp = 1'b1;
        chk({red_led_o, red_relay_o}, 2'h3);
        $display("test panel keys finished");
        panel.ev_q.delete();
        panel.at_q.delete();
        panel.set_key(1'b1);
        ms(`CMC_SLEEP_HOLD_MS - 100);
        chk(rail_o, 3'h7);
        wait_ev(3);
        panel.set_key(1'b0);
        ms(300);
        chk(red_relay_o, !lamp);
        panel.led_flips = 0;
        ms(1000);
        chk(panel.led_flips > 1, 1'b1);
        panel.set_key(1'b1);
        cyc(2);
        panel.set_key(1'b0);
        wait_ev(6);
        foreach (exp_ev[i]) chk(panel.ev_q[i], exp_ev[i]);
        for (int i = 1; i < 6; i++) begin
            j = panel.at_q[i] - panel.at_q[i - 1] - steps[i] * `CMC_SEQ_STEP_MS * TK;
            if (steps[i] > 0) chk(j >= -TK && j <= TK, 1'b1);
        end
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, r);
        chk(r[9:1], {2'h0, lamp, lamp, fol, dm});
        $display("test sleep and wake finished");
        wr(4'h4, 32'h0000_0000); // below range, clamps to shortest
        wr(4'h0, 32'h0000_0001); // idle sleep on, mode none kept
        ms(5000);
        meter_act_i <= 1'b1;
        cyc(1);
        meter_act_i <= 1'b0;
        panel.led_flips = 0;
        ms(`CMC_IDLE_MIN_S * 1000 - 1100);
        chk(rail_o, 3'h7);
        chk(panel.led_flips > 1, 1'b1);
        rd(4'h8, r);
        chk(r[9], 1'b1);
        ms(1600);
        chk(rail_o, 3'h0);
        $display("test idle sleep finished");
        wrap_up;
    end
    // watchdog against a hung run
    initial begin
        cyc(90000);
        miscompares++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up;
    end
endmodule // tb
bind cmc_master_ctrl cmc_props #(.CYC_PER_TICK(CYC_PER_TICK)) u_props (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .btn_i(btn_i), .modifier_i(modifier_i), .xp_select_i(xp_select_i),
    .route_path_i(route_path_i), .re_i(re_i), .rdata_o(rdata_o), .dim_o(dim_o),
    .follow_o(follow_o), .xp_cancel_o(xp_cancel_o), .xp_clear_o(xp_clear_o),
    .xp_path_o(xp_path_o), .red_led_o(red_led_o), .red_relay_o(red_relay_o), .rail_o(rail_o));
